// ===== shared/gtdc_pkg.sv
// package for the gate timing and delay compensation block
// assumes a 200 MHz core clock and a 16-bit serial register port
package gtdc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int DRV_DEAD_NS = 200;
  localparam int DEAD_CYC = (DRV_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUAL_NS = 100;
  localparam int QUAL_CYC = (QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GOAL_STEP_NS = 200;
  localparam int GOAL_STEP_CYC = GOAL_STEP_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] DEAD_CNT = CNT_W'(DEAD_CYC);
  localparam logic [CNT_W-1:0] QUAL_END_CNT = CNT_W'(DEAD_CYC + QUAL_CYC);

  // ==========================================================
  // register map
  localparam logic [5:0] ADDR_RECT_CTRL = 6'h07;
  localparam logic [5:0] ADDR_DELAY_COMP = 6'h0c;
  localparam int ASYNC_RECT_BIT = 3;
  localparam int SYNC_RECT_BIT = 2;
  localparam int COMP_ON_BIT = 4;
  localparam int GOAL_MSB = 3;
  localparam int GOAL_LSB = 0;
  localparam logic [7:0] RECT_CTRL_RST = 8'h00;
  localparam logic [7:0] DELAY_COMP_RST = 8'h00;

  // ==========================================================
  // serial frame: read flag, address, parity, data
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;
  localparam logic [4:0] DATA_START_CNT = 5'h08;
  localparam logic [4:0] FRAME_END_CNT = 5'h10;

  // ==========================================================
  // protection / slew select pin modes that turn demagnetization on
  localparam logic [2:0] PSEL_DEMAG_A = 3'h3;
  localparam logic [2:0] PSEL_DEMAG_B = 3'h4;

  typedef enum logic [1:0] {DM_IDLE, DM_SETTLE, DM_ON} gtdc_dm_state_t;

endpackage

// ===== hdl/gtdc_core.sv
// gate timing core: register port, delay compensation, dead time, demagnetization
// assumes all pins and comparator results are asynchronous to core_clk_in

module gtdc_core
  import gtdc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // serial register port
  input wire logic spi_sclk_in,
  input wire logic spi_ncs_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  // controller pwm inputs, per phase
  input wire logic [2:0] high_side_pwm_in,
  input wire logic [2:0] low_side_pwm_in,
  // demagnetization comparators, per phase
  input wire logic [2:0] demag_high_cmp_in,
  input wire logic [2:0] demag_low_cmp_in,
  // pin-configured variant
  input wire logic hw_variant_in,
  input wire logic [2:0] protect_slew_select_pin_in,
  // gate drive per phase
  output logic [2:0] high_gate_out,
  output logic [2:0] low_gate_out
);

  // ==========================================================
  // functions
  function automatic logic [CNT_W-1:0] goal_cycles(input logic [3:0] code);
    logic [CNT_W-1:0] steps;
    steps = CNT_W'(code) + CNT_W'(1);
    goal_cycles = (code == 4'h0) ? '0 : CNT_W'(steps * CNT_W'(GOAL_STEP_CYC));
  endfunction

  // ==========================================================
  // input synchronisers
  logic [15:0] sync1, sync2;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end else begin
      sync1 <= {spi_sclk_in, ~spi_ncs_in, spi_sdi_in, high_side_pwm_in, low_side_pwm_in,
                demag_high_cmp_in, demag_low_cmp_in, hw_variant_in};
      sync2 <= sync1;
    end
  end
  logic sclk_s, cs_s, sdi_s, hwv_s;
  logic [2:0] hs_s, ls_s, hcmp_s, lcmp_s, psel_s, psel1;
  assign {sclk_s, cs_s, sdi_s, hs_s, ls_s, hcmp_s, lcmp_s, hwv_s} = sync2;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      psel1 <= 3'h0;
      psel_s <= 3'h0;
    end else begin
      psel1 <= protect_slew_select_pin_in;
      psel_s <= psel1;
    end
  end

  // ==========================================================
  // serial register port
  logic [7:0] rect_ctrl, delay_comp;
  logic sclk_d;
  logic [4:0] bit_cnt;
  logic [15:0] rx_sh;
  logic [7:0] tx_sh;
  wire sclk_fall = sclk_d & ~sclk_s;
  wire sclk_rise = ~sclk_d & sclk_s;
  wire [15:0] rx_next = {rx_sh[14:0], sdi_s};

  function automatic logic [7:0] reg_read(input logic [5:0] addr);
    unique case (addr)
      ADDR_RECT_CTRL: reg_read = rect_ctrl;
      ADDR_DELAY_COMP: reg_read = {3'h0, delay_comp[4:0]};
      default: reg_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d <= 1'b0;
      bit_cnt <= 5'h00;
      rx_sh <= 16'h0000;
      tx_sh <= 8'h00;
      spi_sdo_out <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      if (!cs_s) begin
        bit_cnt <= 5'h00;
        spi_sdo_out <= 1'b0;
      end else if (sclk_fall && bit_cnt != FRAME_END_CNT) begin
        rx_sh <= rx_next;
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt + 5'h01 == DATA_START_CNT) begin
          tx_sh <= reg_read(rx_next[6:1]);
        end
      end else if (sclk_rise && bit_cnt >= DATA_START_CNT) begin
        spi_sdo_out <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end
  assign spi_sdo_oe_out = cs_s;

  wire wr_go = cs_s && sclk_fall && bit_cnt == FRAME_END_CNT - 5'h01 && !rx_sh[RW_BIT - 1];
  wire [5:0] wr_addr = rx_sh[ADDR_MSB-1:ADDR_LSB-1];
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rect_ctrl <= RECT_CTRL_RST;
      delay_comp <= DELAY_COMP_RST;
    end else if (wr_go) begin
      if (wr_addr == ADDR_RECT_CTRL) begin
        rect_ctrl <= {4'h0, rx_next[ASYNC_RECT_BIT], rx_next[SYNC_RECT_BIT], 2'h0};
      end
      if (wr_addr == ADDR_DELAY_COMP) begin
        delay_comp <= {3'h0, rx_next[4:0]};
      end
    end
  end

  wire delay_comp_on = delay_comp[COMP_ON_BIT];
  wire [3:0] delay_goal_code = delay_comp[GOAL_MSB:GOAL_LSB];
  wire sync_rectify_on = rect_ctrl[SYNC_RECT_BIT];
  wire async_rectify_on = rect_ctrl[ASYNC_RECT_BIT];
  wire [CNT_W-1:0] goal_now = goal_cycles(delay_goal_code);
  wire demag_on = (sync_rectify_on && async_rectify_on) ||
                  (hwv_s && (psel_s == PSEL_DEMAG_A || psel_s == PSEL_DEMAG_B));

  // ==========================================================
  // delay compensation: turn-offs pass at once, turn-ons wait out the goal
  logic [2:0] seen_h, seen_l, req_h, req_l, busy;
  logic [CNT_W-1:0] dly_cnt [3];
  wire [2:0] edge_in = (hs_s ^ seen_h) | (ls_s ^ seen_l);
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seen_h <= 3'h0;
      seen_l <= 3'h0;
      req_h <= 3'h0;
      req_l <= 3'h0;
      busy <= 3'h0;
      for (int p = 0; p < 3; p++) dly_cnt[p] <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (edge_in[p]) begin
          seen_h[p] <= hs_s[p];
          seen_l[p] <= ls_s[p];
          // settings are sampled only here
          if (delay_comp_on && goal_now != '0) begin
            req_h[p] <= req_h[p] & hs_s[p];
            req_l[p] <= req_l[p] & ls_s[p];
            dly_cnt[p] <= goal_now - CNT_W'(1);
            busy[p] <= 1'b1;
          end else begin
            req_h[p] <= hs_s[p];
            req_l[p] <= ls_s[p];
            busy[p] <= 1'b0;
          end
        end else if (busy[p]) begin
          if (dly_cnt[p] == '0) begin
            req_h[p] <= seen_h[p];
            req_l[p] <= seen_l[p];
            busy[p] <= 1'b0;
          end else begin
            dly_cnt[p] <= dly_cnt[p] - CNT_W'(1);
          end
        end
      end
    end
  end

  // ==========================================================
  // dead time: a gate turns on only after the other has been off DEAD_CYC
  logic [CNT_W-1:0] hi_off_cnt [3];
  logic [CNT_W-1:0] lo_off_cnt [3];
  gtdc_dm_state_t dm_st [3][2]; // side 0 drives low FET, side 1 high FET
  logic [CNT_W-1:0] dm_cnt [3][2];
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int p = 0; p < 3; p++) begin
        hi_off_cnt[p] <= '0;
        lo_off_cnt[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (high_gate_out[p]) hi_off_cnt[p] <= '0;
        else if (hi_off_cnt[p] != DEAD_CNT) hi_off_cnt[p] <= hi_off_cnt[p] + CNT_W'(1);
        if (low_gate_out[p]) lo_off_cnt[p] <= '0;
        else if (lo_off_cnt[p] != DEAD_CNT) lo_off_cnt[p] <= lo_off_cnt[p] + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      high_gate_out <= 3'h0;
      low_gate_out <= 3'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        // a long controller gap has already filled the counter
        // counter is one short on the edge that turns the gate on: off time is DEAD_CYC
        // same wait whatever the current direction
        high_gate_out[p] <= (req_h[p] && !req_l[p] && !low_gate_out[p] &&
                             lo_off_cnt[p] >= DEAD_CNT - CNT_W'(1)) || dm_st[p][1] == DM_ON;
        // low FET stays off unless requested or demagnetizing
        low_gate_out[p] <= (req_l[p] && !req_h[p] && !high_gate_out[p] &&
                            hi_off_cnt[p] >= DEAD_CNT - CNT_W'(1)) || dm_st[p][0] == DM_ON;
      end
    end
  end

  // ==========================================================
  // demagnetization: after one gate drops with both inputs off, watch the body diode
  logic [2:0] hi_d, lo_d;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hi_d <= 3'h0;
      lo_d <= 3'h0;
      for (int p = 0; p < 3; p++) begin
        for (int s = 0; s < 2; s++) begin
          dm_st[p][s] <= DM_IDLE;
          dm_cnt[p][s] <= '0;
        end
      end
    end else begin
      hi_d <= high_gate_out;
      lo_d <= low_gate_out;
      for (int p = 0; p < 3; p++) begin
        for (int s = 0; s < 2; s++) begin
          logic dropped, cmp;
          dropped = (s == 0) ? (hi_d[p] && !high_gate_out[p]) : (lo_d[p] && !low_gate_out[p]);
          cmp = (s == 0) ? lcmp_s[p] : hcmp_s[p];
          if (!demag_on || req_h[p] || req_l[p]) begin
            dm_st[p][s] <= DM_IDLE;
          end else begin
            unique case (dm_st[p][s])
              DM_IDLE: begin
                if (dropped) begin
                  dm_st[p][s] <= DM_SETTLE;
                  dm_cnt[p][s] <= '0;
                end
              end
              DM_SETTLE: begin
                if (dm_cnt[p][s] < DEAD_CNT || cmp) begin
                  dm_cnt[p][s] <= dm_cnt[p][s] + CNT_W'(1);
                end else begin
                  dm_cnt[p][s] <= DEAD_CNT;
                end
                if (cmp && dm_cnt[p][s] == QUAL_END_CNT - CNT_W'(1)) begin
                  dm_st[p][s] <= DM_ON;
                end
              end
              DM_ON: begin
                if (!cmp) dm_st[p][s] <= DM_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

  // ==========================================================
  // assertions, watching phase 0
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  comp_bypass_a: assert property (edge_in[0] && !delay_comp_on |=> req_h[0] == $past(hs_s[0]))
    else $error("bypassed edge not applied at once");
  goal_load_a: assert property (edge_in[0] && delay_comp_on && delay_goal_code != 4'h0
    |=> busy[0] && dly_cnt[0] == $past(goal_now) - CNT_W'(1))
    else $error("goal count loaded wrong");
  late_turn_on_a: assert property ($rose(req_h[0]) |-> $past(edge_in[0] || busy[0]))
    else $error("turn-on request without input edge or delay end");
  demag_gate_a: assert property (!demag_on |=> dm_st[0][0] == DM_IDLE && dm_st[0][1] == DM_IDLE)
    else $error("demag active while disabled");
  demag_start_a: assert property ($rose(dm_st[0][0] == DM_SETTLE) |-> $fell(high_gate_out[0])
    or $past(hi_d[0] && !high_gate_out[0]))
    else $error("demag started without high-side turn-off");
  diode_only_a: assert property (!demag_on && $past(!demag_on) && !req_l[0] |=> !low_gate_out[0])
    else $error("low FET on with demag disabled");
  demag_qual_a: assert property ($rose(dm_st[0][0] == DM_ON)
    |-> $past(lcmp_s[0]) && $past(dm_cnt[0][0]) == QUAL_END_CNT - CNT_W'(1))
    else $error("demag turned on without qualification");
  demag_release_a: assert property (dm_st[0][0] == DM_ON && !lcmp_s[0] && !req_l[0]
    |=> dm_st[0][0] == DM_IDLE ##1 !low_gate_out[0])
    else $error("demag FET not released");
  own_dead_a: assert property ($rose(high_gate_out[0]) |-> lo_off_cnt[0] == DEAD_CNT)
    else $error("high gate on inside dead time");
  follow_mcu_a: assert property ($rose(req_h[0]) && !req_l[0] && !low_gate_out[0]
    && lo_off_cnt[0] == DEAD_CNT && dm_st[0][1] != DM_ON |=> high_gate_out[0])
    else $error("extra delay added after long controller gap");
  cfg_hold_a: assert property (busy[0] && !edge_in[0] && dly_cnt[0] != '0
    |=> dly_cnt[0] == $past(dly_cnt[0]) - CNT_W'(1))
    else $error("running delay disturbed");
  rsvd_zero_a: assert property (delay_comp[7:5] == 3'h0)
    else $error("reserved bits set");

  comp_turn_on_c: cover property (busy[0] ##1 !busy[0] && $rose(req_h[0]));
  demag_on_c: cover property (dm_st[0][0] == DM_SETTLE ##1 dm_st[0][0] == DM_ON);
  reg_write_c: cover property (wr_go && wr_addr == ADDR_DELAY_COMP);
  mcu_gap_c: cover property ($rose(req_h[0]) && lo_off_cnt[0] == DEAD_CNT);

endmodule

// ===== verif/gtdc_mcu_model.sv
// controller model: drives the per-phase high and low side pwm requests
// assumes the bench calls its tasks and feeds it the core clock
module gtdc_mcu_model (
  // clock
  input wire logic clk_in,
  // pwm requests per phase
  output logic [2:0] high_pwm_out,
  output logic [2:0] low_pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================
  // request drivers, all changes just after a falling clock edge
  initial begin
    high_pwm_out = 3'h0;
    low_pwm_out = 3'h0;
  end

  task automatic set_lvl(input int p, input logic h, input logic l);
    @(negedge clk_in);
    high_pwm_out[p] = h;
    low_pwm_out[p] = l;
  endtask

  // complementary swap: conducting side drops first, then own dead time
  task automatic commute(input int p, input logic to_high, input int dead);
    @(negedge clk_in);
    if (to_high) low_pwm_out[p] = 1'b0;
    else high_pwm_out[p] = 1'b0;
    repeat (dead) @(negedge clk_in);
    if (to_high) high_pwm_out[p] = 1'b1;
    else low_pwm_out[p] = 1'b1;
  endtask
endmodule

// ===== verif/gate_timing_delay_comp_tb.sv
// self-checking bench for gtdc_core: registers, dead time, compensation, demagnetization
// assumes gtdc_pkg and gtdc_mcu_model are compiled first
module gate_timing_delay_comp_tb import gtdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================
  // signals
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic spi_sclk_in = 1'b0;
  logic spi_ncs_in = 1'b1;
  logic spi_sdi_in = 1'b0;
  logic spi_sdo_out, spi_sdo_oe_out;
  logic [2:0] high_side_pwm_in, low_side_pwm_in;
  logic [2:0] demag_high_cmp_in = 3'h0;
  logic [2:0] demag_low_cmp_in = 3'h0;
  logic hw_variant_in = 1'b0;
  logic [2:0] protect_slew_select_pin_in = 3'h0;
  logic [2:0] high_gate_out, low_gate_out;
  int n_errors = 0;
  int cmp_count = 0;
  int dl[5] = '{0, 39, 41, 80, 0};
  logic [7:0] cfg;

  always #2.5 core_clk_in = ~core_clk_in;

  gtdc_core u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .spi_sclk_in(spi_sclk_in),
    .spi_ncs_in(spi_ncs_in), .spi_sdi_in(spi_sdi_in), .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oe_out(spi_sdo_oe_out), .high_side_pwm_in(high_side_pwm_in),
    .low_side_pwm_in(low_side_pwm_in), .demag_high_cmp_in(demag_high_cmp_in),
    .demag_low_cmp_in(demag_low_cmp_in), .hw_variant_in(hw_variant_in),
    .protect_slew_select_pin_in(protect_slew_select_pin_in),
    .high_gate_out(high_gate_out), .low_gate_out(low_gate_out));

  gtdc_mcu_model u_mcu (.clk_in(core_clk_in), .high_pwm_out(high_side_pwm_in),
    .low_pwm_out(low_side_pwm_in));

  // ======================================
  // checking and reference model
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // gap from old gate off to new gate on, d = controller dead time
  function automatic int exp_gap(input int d, input logic [7:0] r);
    int g;
    g = d;
    if (r[COMP_ON_BIT] && r[GOAL_MSB:GOAL_LSB] != 4'h0) begin
      g = (r[GOAL_MSB:GOAL_LSB] + 1) * GOAL_STEP_CYC + d;
    end
    return (g > DEAD_CYC) ? g : DEAD_CYC;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ======================================
  // serial register port, one 16-bit frame
  task automatic spi_frame(input logic rd, input logic [5:0] a, input logic [7:0] wd,
                           output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, 1'b0, wd};
    q = 8'h00;
    spi_ncs_in = 1'b0;
    repeat (5) @(negedge core_clk_in);
    // data changes with the rising clock and stands across the sampling fall
    for (int i = 15; i >= 0; i--) begin
      spi_sclk_in = 1'b1;
      spi_sdi_in = f[i];
      repeat (5) @(negedge core_clk_in);
      if (i < 8) q = {q[6:0], spi_sdo_out};
      if (i == 15) check(spi_sdo_oe_out, 1'b1);
      spi_sclk_in = 1'b0;
      repeat (5) @(negedge core_clk_in);
    end
    spi_ncs_in = 1'b1;
    spi_sdi_in = ~spi_sdi_in;
    repeat (6) @(negedge core_clk_in);
    check(spi_sdo_oe_out, 1'b0);
  endtask

  task automatic reg_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    spi_frame(1'b1, a, 8'h00, q);
    check(q, exp);
  endtask

  // ======================================
  // pwm swap measured at the gates
  task automatic swap(input int p, input logic to_high, input int d);
    int t_off, t_on;
    t_off = -1;
    t_on = -1;
    fork
      u_mcu.commute(p, to_high, d);
    join_none
    for (int t = 0; t < 1000 && t_on < 0; t++) begin
      @(posedge core_clk_in);
      #1;
      if (t_off < 0 && (to_high ? low_gate_out[p] : high_gate_out[p]) === 1'b0) t_off = t;
      if (t_on < 0 && (to_high ? high_gate_out[p] : low_gate_out[p]) === 1'b1) t_on = t;
    end
    check(t_on - t_off, exp_gap(d, cfg));
  endtask

  task automatic run_pair(input int p, input int d);
    swap(p, 1'b1, d);
    swap(p, 1'b0, d);
  endtask

  task automatic demag_run(input int p, input logic on);
    int t_on;
    u_mcu.set_lvl(p, 1'b1, 1'b0);
    repeat (60) @(negedge core_clk_in);
    demag_low_cmp_in[p] = 1'b1;
    u_mcu.set_lvl(p, 1'b0, 1'b0);
    t_on = -1;
    for (int t = 0; t < 150 && t_on < 0; t++) begin
      @(posedge core_clk_in);
      #1;
      if (low_gate_out[p] === 1'b1) t_on = t;
    end
    if (on) check(t_on >= DEAD_CYC + QUAL_CYC && t_on <= DEAD_CYC + QUAL_CYC + 8, 1);
    else check(t_on, -1);
    @(negedge core_clk_in);
    demag_low_cmp_in[p] = 1'b0;
    repeat (8) @(negedge core_clk_in);
    check(low_gate_out[p], 1'b0);
  endtask

  // ======================================
  // main sequence
  initial begin
    logic [7:0] q;
    void'($urandom(32'h3585));
    dl[4] = $urandom_range(120);
    repeat (10) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    reg_chk(ADDR_DELAY_COMP, DELAY_COMP_RST);
    reg_chk(ADDR_RECT_CTRL, RECT_CTRL_RST);
    spi_frame(1'b0, ADDR_DELAY_COMP, 8'hff, q);
    reg_chk(ADDR_DELAY_COMP, 8'h1f);
    reg_chk(6'h3f, 8'h00);
    $display("test registers done");
    cfg = 8'h0f;
    spi_frame(1'b0, ADDR_DELAY_COMP, cfg, q);
    for (int p = 0; p < 3; p++) u_mcu.set_lvl(p, 1'b0, 1'b1);
    repeat (60) @(negedge core_clk_in);
    foreach (dl[i]) run_pair(i % 3, dl[i]);
    $display("test dead time done");
    for (int c = 0; c < 16; c++) begin
      cfg = 8'h10 | 8'(c); // software sweeps the goal it would pick
      spi_frame(1'b0, ADDR_DELAY_COMP, cfg, q);
      run_pair(c % 3, $urandom_range(60));
    end
    $display("test compensation done");
    spi_frame(1'b0, ADDR_DELAY_COMP, 8'h00, q);
    reg_chk(ADDR_DELAY_COMP, 8'h00);
    spi_frame(1'b0, ADDR_RECT_CTRL, 8'hff, q);
    reg_chk(ADDR_RECT_CTRL, 8'h0c);
    demag_run(0, 1'b1);
    spi_frame(1'b0, ADDR_RECT_CTRL, 8'h04, q);
    demag_run(1, 1'b0);
    spi_frame(1'b0, ADDR_RECT_CTRL, 8'h00, q);
    hw_variant_in = 1'b1;
    for (int m = 0; m < 8; m++) begin
      protect_slew_select_pin_in = m[2:0];
      demag_run(m % 3, m == PSEL_DEMAG_A || m == PSEL_DEMAG_B);
    end
    $display("test demagnetization done");
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge core_clk_in);
    n_errors++;
    tally_and_finish();
  end
endmodule
